// *** rtl/sps_pkg.sv ***
// package: constants and carrier types for the register page stack block
package sps_pkg;

  // register bus geometry
  localparam int          AXI_AW        = 8;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;  // page_control_register
  localparam logic [7:0]  OFS_PAGE      = 8'h04;  // active_page_register
  localparam logic [7:0]  OFS_LEVEL2    = 8'h08;  // page_stack_level_two
  localparam logic [7:0]  OFS_LEVEL3    = 8'h0c;  // page_stack_level_three
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // page_control_register fields and reset values
  localparam int          CTRL_AUTO_BIT = 0;      // page_autoswitch_enable
  localparam logic [7:0]  CTRL_MASK     = 8'h01;  // other bits reserved, read zero
  localparam logic [7:0]  CTRL_RESET    = 8'h01;
  localparam logic [7:0]  PAGE_RESET    = 8'h00;

  // address space split and working register banks
  localparam int          SPACE_BIT     = 7;      // set: register space on direct access
  localparam int          BANK_REGS_W   = 3;      // eight registers per bank
  localparam int          N_ALL_PAGE    = 4;
  localparam logic [7:0]  ALL_PAGE_ADDRS [N_ALL_PAGE] = '{8'h80, 8'h90, 8'ha0, 8'hb0};

  // kind of operand the core asks to be mapped
  typedef enum logic [1:0] {
    SPS_ACC_DIRECT   = 2'h0,
    SPS_ACC_INDIRECT = 2'h1,
    SPS_ACC_WORKREG  = 2'h3
  } sps_acc_t;

  typedef struct packed {
    logic       valid;
    sps_acc_t   kind;
    logic [7:0] addr;   // register number in addr[2:0] for working registers
    logic [1:0] bank;   // currently selected register bank
  } sps_req_t;

  typedef struct packed {
    logic       valid;
    logic       ram_sel;
    logic       sfr_sel;
    logic       all_page;
    logic [7:0] addr;
    logic [7:0] page;
  } sps_map_t;

endpackage : sps_pkg

// *** rtl/sps_addr_decode.sv ***
// module: combinational decode of a core operand into data ram or paged register space
`timescale 1ns/1ps
module sps_addr_decode (
  // operand and current page
  input  wire sps_pkg::sps_req_t req,
  input  wire logic [7:0]        page,
  // decoded target
  output sps_pkg::sps_map_t      map
);

  logic [sps_pkg::N_ALL_PAGE-1:0] hit;

  // one comparator per all-page location
  genvar gi;
  generate
    for (gi = 0; gi < sps_pkg::N_ALL_PAGE; gi++) begin : g_all
      assign hit[gi] = (req.addr == sps_pkg::ALL_PAGE_ADDRS[gi]);
    end
  endgenerate

  // split the address space by access kind
  always_comb begin
    map       = '0;
    map.valid = req.valid;
    unique case (req.kind)
      sps_pkg::SPS_ACC_DIRECT: begin
        map.addr = req.addr;
        if (req.addr[sps_pkg::SPACE_BIT]) begin
          map.sfr_sel  = 1'b1;
          map.all_page = |hit;
          map.page     = (|hit) ? 8'h00 : page;  // all-page ignores the page value
        end else begin
          map.ram_sel = 1'b1;
        end
      end
      sps_pkg::SPS_ACC_INDIRECT: begin
        map.ram_sel = 1'b1;
        map.addr    = req.addr;
      end
      sps_pkg::SPS_ACC_WORKREG: begin
        map.ram_sel = 1'b1;
        map.addr    = {3'h0, req.bank, req.addr[sps_pkg::BANK_REGS_W-1:0]};
      end
      default: map = '0;                         // code 2 is illegal
    endcase
  end

endmodule : sps_addr_decode

// *** rtl/sps_top.sv ***
// module: register page stack with autoswitch, operand decode and register bus slave
// Functional notes
// - software can turn off hardware page switching on interrupts via the control register.
// - after any reset the autoswitch enable reads as set.
// - on return from interrupt with autoswitch on, the active page takes the level-two value.
// - in that same pop, level two takes the level-three value.
// - all-page registers decode at their address whatever the active page is.
// - direct addresses 0x00-0x7f go to data ram, 0x80-0xff to the paged register space.
// - the lower 128 bytes of data ram are reachable both directly and indirectly.
// - ram 0x00-0x1f forms four banks of eight working registers, picked by the bank select.
`timescale 1ns/1ps
module sps_top (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // axi4-lite write address and data
  input  wire logic [sps_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // axi4-lite read
  input  wire logic [sps_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // core interrupt events
  input  wire logic                       irq_entry,
  input  wire logic [7:0]                 irq_page,
  input  wire logic                       irq_return,
  // core operand decode
  input  wire sps_pkg::sps_req_t          core_req,
  output sps_pkg::sps_map_t               core_map,
  // page state toward the core
  output logic [7:0]                      active_page,
  output logic                            page_autoswitch_enable
);

  // write channel holding state
  logic                      aw_full_q, aw_full_d;
  logic                      w_full_q,  w_full_d;
  logic [sps_pkg::AXI_AW-1:0] waddr_q,  waddr_d;
  logic [7:0]                wbyte_q,   wbyte_d;
  logic                      wlane_q,   wlane_d;
  logic                      awready_q, awready_d;
  logic                      wready_q,  wready_d;
  logic                      bvalid_q,  bvalid_d;
  logic [1:0]                bresp_q,   bresp_d;
  // read channel state
  logic                      arready_q, arready_d;
  logic                      rvalid_q,  rvalid_d;
  logic [31:0]               rdata_q,   rdata_d;
  logic [1:0]                rresp_q,   rresp_d;
  // page stack and control
  logic [7:0]                ctrl_q,   ctrl_d;
  logic [7:0]                page_q,   page_d;
  logic [7:0]                level2_q, level2_d;
  logic [7:0]                level3_q, level3_d;
  // decode
  sps_pkg::sps_map_t         map_c;
  sps_pkg::sps_map_t         map_q;
  logic                      do_write;
  logic                      auto_en;

  assign auto_en  = ctrl_q[sps_pkg::CTRL_AUTO_BIT];
  assign do_write = aw_full_q && w_full_q && !bvalid_q;

  // write channel: address and data taken in either order, response after both
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    waddr_d   = waddr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      waddr_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      wbyte_d  = s_axi_wdata[7:0];
      wlane_d  = s_axi_wstrb[0];  // only byte lane 0 carries register bits
    end
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      unique case (waddr_q)
        sps_pkg::OFS_CTRL, sps_pkg::OFS_PAGE,
        sps_pkg::OFS_LEVEL2, sps_pkg::OFS_LEVEL3: bresp_d = sps_pkg::RESP_OKAY;
        default:                                  bresp_d = sps_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // readies drop as soon as a beat is held, so nothing is taken twice
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      waddr_q   <= '0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= sps_pkg::RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      waddr_q   <= waddr_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // page stack: hardware push and pop win over a software write in the same cycle
  always_comb begin
    ctrl_d   = ctrl_q;
    page_d   = page_q;
    level2_d = level2_q;
    level3_d = level3_q;
    if (do_write && wlane_q) begin
      unique case (waddr_q)
        sps_pkg::OFS_CTRL:   ctrl_d   = wbyte_q & sps_pkg::CTRL_MASK;
        sps_pkg::OFS_PAGE:   page_d   = wbyte_q;
        sps_pkg::OFS_LEVEL2: level2_d = wbyte_q;
        sps_pkg::OFS_LEVEL3: level3_d = wbyte_q;
        default: ;
      endcase
    end
    // entry beats a return arriving in the same cycle; nothing moves when off
    if (auto_en && irq_entry) begin
      level3_d = level2_q;
      level2_d = page_q;
      page_d   = irq_page;
    end else if (auto_en && irq_return) begin
      page_d   = level2_q;
      level2_d = level3_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q   <= sps_pkg::CTRL_RESET;
      page_q   <= sps_pkg::PAGE_RESET;
      level2_q <= sps_pkg::PAGE_RESET;
      level3_q <= sps_pkg::PAGE_RESET;
    end else begin
      ctrl_q   <= ctrl_d;
      page_q   <= page_d;
      level2_q <= level2_d;
      level3_q <= level3_d;
    end
  end

  // read channel: one outstanding read, data one cycle after the address
  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = sps_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sps_pkg::OFS_CTRL:   rdata_d = {24'h000000, ctrl_q};
        sps_pkg::OFS_PAGE:   rdata_d = {24'h000000, page_q};
        sps_pkg::OFS_LEVEL2: rdata_d = {24'h000000, level2_q};
        sps_pkg::OFS_LEVEL3: rdata_d = {24'h000000, level3_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = sps_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end else if (!rvalid_q) begin
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= sps_pkg::RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // operand decode uses the page as it stands this cycle
  sps_addr_decode u_decode (
    .req  (core_req),
    .page (page_q),
    .map  (map_c)
  );

  // registered so every core-facing output comes from a flop; one cycle latency
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      map_q <= '0;
    end else begin
      map_q <= map_c;
    end
  end

  assign s_axi_awready          = awready_q;
  assign s_axi_wready           = wready_q;
  assign s_axi_bvalid           = bvalid_q;
  assign s_axi_bresp            = bresp_q;
  assign s_axi_arready          = arready_q;
  assign s_axi_rvalid           = rvalid_q;
  assign s_axi_rdata            = rdata_q;
  assign s_axi_rresp            = rresp_q;
  assign core_map               = map_q;
  assign active_page            = page_q;
  assign page_autoswitch_enable = ctrl_q[sps_pkg::CTRL_AUTO_BIT];

endmodule : sps_top

// *** bench/sps_top_chk.sv ***
// checker: port-level assertions for the register page stack block
`timescale 1ns/1ps
module sps_top_chk (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // bus idle indication
  input  wire logic              s_axi_awready,
  // core side
  input  wire logic              irq_entry,
  input  wire logic [7:0]        irq_page,
  input  wire logic              irq_return,
  input  wire sps_pkg::sps_req_t core_req,
  input  wire sps_pkg::sps_map_t core_map,
  input  wire logic [7:0]        active_page,
  input  wire logic              page_autoswitch_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // operand classes, decoded once so the properties stay short
  wire logic       dir_q  = core_req.valid && core_req.kind == sps_pkg::SPS_ACC_DIRECT;
  wire logic       ind_q  = core_req.valid && core_req.kind == sps_pkg::SPS_ACC_INDIRECT;
  wire logic       reg_q  = core_req.valid && core_req.kind == sps_pkg::SPS_ACC_WORKREG;
  wire logic       allp_q = core_req.addr[7:6] == 2'h2 && core_req.addr[3:0] == 4'h0;
  wire logic [7:0] bank_a = {3'h0, core_req.bank, core_req.addr[2:0]};

  a_reset_auto_on: assert property (disable iff (1'b0) sys_rst |=>
    page_autoswitch_enable) else $error("autoswitch enable not set after reset");
  a_entry_loads_page: assert property (irq_entry && page_autoswitch_enable |=>
    active_page == $past(irq_page)) else $error("entry did not load the peripheral page");
  // awready high means no bus write can land at this edge
  a_frozen_page: assert property ((irq_entry || irq_return) &&
    !page_autoswitch_enable && s_axi_awready |=> $stable(active_page))
    else $error("page moved with autoswitch off");
  a_direct_ram: assert property (dir_q && !core_req.addr[7] |=> core_map.valid &&
    core_map.ram_sel && !core_map.sfr_sel && core_map.addr == $past(core_req.addr))
    else $error("low direct address not mapped to ram");
  a_paged_sfr: assert property (dir_q && core_req.addr[7] && !allp_q |=>
    core_map.sfr_sel && !core_map.all_page && core_map.page == $past(active_page))
    else $error("paged decode wrong");
  a_all_page: assert property (dir_q && allp_q |=> core_map.sfr_sel &&
    core_map.all_page && core_map.page == 8'h00)
    else $error("all-page register decoded by page");
  a_indirect_ram: assert property (ind_q |=> core_map.ram_sel && !core_map.sfr_sel &&
    core_map.addr == $past(core_req.addr)) else $error("indirect access not in ram");
  a_bank_regs: assert property (reg_q |=> core_map.ram_sel &&
    core_map.addr == $past(bank_a)) else $error("working register slot wrong");
endmodule : sps_top_chk

bind sps_top sps_top_chk chk (.clk(clk), .sys_rst(sys_rst), .s_axi_awready(s_axi_awready),
  .irq_entry(irq_entry), .irq_page(irq_page), .irq_return(irq_return), .core_req(core_req),
  .core_map(core_map), .active_page(active_page),
  .page_autoswitch_enable(page_autoswitch_enable));

// *** bench/sps_core_model.sv ***
// core model: drives interrupt events and operands toward the page stack block
`timescale 1ns/1ps
module sps_core_model (
  // clock
  input  wire logic         clk,
  // toward the block
  output sps_pkg::sps_req_t core_req,
  output logic [7:0]        irq_page,
  output logic              irq_entry,
  output logic              irq_return
);
  initial begin
    core_req   = '0;
    irq_page   = 8'h00;
    irq_entry  = 1'b0;
    irq_return = 1'b0;
  end
  // one cycle of events; an idle page shows the inverse so a stale value never looks valid
  task automatic ev(input logic e, input logic r, input logic [7:0] p);
    irq_entry  <= e;
    irq_return <= r;
    irq_page   <= e ? p : ~irq_page;
    @(posedge clk);
  endtask : ev
  // one operand per cycle, as a core issuing back to back
  task automatic dec(input sps_pkg::sps_req_t q);
    core_req <= q;
    @(posedge clk);
  endtask : dec
endmodule : sps_core_model

// *** bench/sps_top_test.sv ***
// testbench: bus and core stimulus with queued expectations for the page stack block
`timescale 1ns/1ps
module sps_top_test;
  logic              clk = 1'b0, sys_rst = 1'b1;
  logic [7:0]        awa = 8'h00, ara = 8'h00, p [3];
  logic              awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [31:0]       wd = 32'h0, rd_q;
  logic [3:0]        ws = 4'hf;
  logic              awr, wr_q, bv, arr, rv, ie, ir, auto;
  logic [1:0]        bresp, rresp;
  logic [7:0]        ip, page;
  sps_pkg::sps_req_t req;
  sps_pkg::sps_map_t map;
  logic [33:0]       expq [$];
  int                fails = 0, comparisons = 0, seed = 14250, i;

  always #5 clk = ~clk;

  sps_top dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_q), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_q),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .irq_entry(ie), .irq_page(ip),
    .irq_return(ir), .core_req(req), .core_map(map), .active_page(page),
    .page_autoswitch_enable(auto));
  sps_core_model core (.clk(clk), .core_req(req), .irq_page(ip), .irq_entry(ie), .irq_return(ir));

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // each bus answer is judged against the oldest note
  always @(posedge clk) begin
    if ((rv && rr) || (bv && br)) begin
      if (expq.size() == 0) chk(34'h0, 34'h3ffffffff);
      else chk((rv && rr) ? {rresp, rd_q} : {bresp, 32'h0}, expq.pop_front());
    end
  end

  task automatic tmo(input int n);
    if (n >= 50) begin
      fails++;
      $display("unexpected at %0t: bus wait ran out", $time);
      stop_test();
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    expq.push_back({r, 32'h0});
    awa <= a;
    wd  <= {24'h0, d};
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    n = 0;
    // raised flags only show after this time step, so pass an edge before testing them
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_q) wv <= 1'b0;
      if (bv) br <= 1'b0;
      n++;
    end while (n < 50 && (awv || wv || br));
    tmo(n);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    expq.push_back({r, 24'h0, d});
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) rr <= 1'b0;
      n++;
    end while (n < 50 && (arv || rr));
    tmo(n);
  endtask : rd

  task automatic stack(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    rd(sps_pkg::OFS_PAGE, a, sps_pkg::RESP_OKAY);
    rd(sps_pkg::OFS_LEVEL2, b, sps_pkg::RESP_OKAY);
    rd(sps_pkg::OFS_LEVEL3, c, sps_pkg::RESP_OKAY);
  endtask : stack

  task automatic stop_test();
    $display("counts: comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(sps_pkg::OFS_CTRL, sps_pkg::CTRL_RESET, sps_pkg::RESP_OKAY);
    stack(sps_pkg::PAGE_RESET, sps_pkg::PAGE_RESET, sps_pkg::PAGE_RESET);
    rd(8'h10, 8'h00, sps_pkg::RESP_SLVERR);
    wr(8'h14, 8'h5a, sps_pkg::RESP_SLVERR);
    $display("reset test ends");
    for (i = 0; i < 3; i++) p[i] = 8'($random(seed));
    // back-to-back entries; the last arrives with a return, which must lose
    core.ev(1'b1, 1'b0, p[0]);
    core.ev(1'b1, 1'b0, p[1]);
    core.ev(1'b1, 1'b1, p[2]);
    core.ev(1'b0, 1'b0, 8'h00);
    stack(p[2], p[1], p[0]);
    core.ev(1'b0, 1'b1, 8'h00);
    core.ev(1'b0, 1'b0, 8'h00);
    stack(p[1], p[0], p[0]);
    $display("push and pop test ends");
    wr(sps_pkg::OFS_CTRL, 8'h00, sps_pkg::RESP_OKAY);
    core.ev(1'b1, 1'b0, 8'h77);
    core.ev(1'b0, 1'b1, 8'h00);
    core.ev(1'b0, 1'b0, 8'h00);
    stack(p[1], p[0], p[0]);
    rd(sps_pkg::OFS_CTRL, 8'h00, sps_pkg::RESP_OKAY);
    wr(sps_pkg::OFS_CTRL, 8'h01, sps_pkg::RESP_OKAY);
    wr(sps_pkg::OFS_LEVEL2, 8'h3c, sps_pkg::RESP_OKAY);
    core.ev(1'b0, 1'b1, 8'h00);
    repeat (3) core.ev(1'b0, 1'b0, 8'h00);
    stack(8'h3c, p[0], p[0]);
    // a write with byte lane 0 off is answered but must store nothing
    ws <= 4'he;
    wr(sps_pkg::OFS_LEVEL3, 8'ha5, sps_pkg::RESP_OKAY);
    ws <= 4'hf;
    rd(sps_pkg::OFS_LEVEL3, p[0], sps_pkg::RESP_OKAY);
    $display("autoswitch off test ends");
    for (i = 0; i < sps_pkg::N_ALL_PAGE; i++)
      core.dec({1'b1, sps_pkg::SPS_ACC_DIRECT, sps_pkg::ALL_PAGE_ADDRS[i], 2'h1});
    for (i = 0; i < 200; i++)
      core.dec(sps_pkg::sps_req_t'({1'b1, 12'($random(seed))}));
    core.dec('0);
    $display("decode test ends");
    // clear the enable first so the mid-run reset has something to restore
    wr(sps_pkg::OFS_CTRL, 8'h00, sps_pkg::RESP_OKAY);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(sps_pkg::OFS_CTRL, sps_pkg::CTRL_RESET, sps_pkg::RESP_OKAY);
    stack(sps_pkg::PAGE_RESET, sps_pkg::PAGE_RESET, sps_pkg::PAGE_RESET);
    $display("second reset test ends");
    stop_test();
  end
endmodule : sps_top_test
